// file: logic/bpb_port_block.sv
// Bit-programmable three-state port block with control mode and register port
//
// Notes on behaviour
// R1 - Reset sets all direction bits: inputs
// R2 - Latches hold no meaningful value after reset
// R3 - Software loads latch before enabling output
// R4 - Ports 2 and 7 have no driver
// R5 - Port widths limited by per-port masks
// R6 - Output bit reads back latch value
// R7 - Latch supports bit set/clear and port writes
// R8 - Input bit reads pin, never latch
// R9 - Writes update latch regardless of direction
// R10 - Switching to output drives latch at once
// R11 - Control select hands pin to peripheral
// R12 - Direction ignored for drive in control mode
// R13 - Control output, direction 1: read pin
// R14 - Control output, direction 0: read internal signal
// R15 - Control input, direction 0 reads zero
// R16 - Control select set only during initialisation
// R17 - External-only mode frees ports 4,5,9 low
// R18 - Port 4 direction from expansion mode register
// R19 - Port 0 low nibble outputs realtime signals
// R20 - Read mux uses that bit's select bits
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "bpb_cfg.svh"

module bpb_port_block (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [`BPB_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Port pins, index is port number
    input wire logic [9:0][7:0] pin_in,
    output logic [9:0][7:0] pin_out,
    output logic [9:0][7:0] pin_oe,
    // Peripheral control signals
    input wire logic [9:0][7:0] ctl_out,
    input wire logic [9:0][7:0] ctl_dir_out,
    input wire logic [3:0] realtime_out_signals,
    output logic [9:0][7:0] ctl_in,
    // Running from external memory only, asynchronous level
    input wire logic ext_mem_only
);

    // Current and next state
    bpb_pkg::bpb_state_s st_q;
    bpb_pkg::bpb_state_s st_d;

    // Valid bit mask of a port
    function automatic logic [7:0] port_mask(input int p);
        logic [7:0] m;
        m = 8'h00;
        case (p)
            0: m = `BPB_MASK_P0;
            1: m = `BPB_MASK_P1;
            2: m = `BPB_MASK_P2;
            3: m = `BPB_MASK_P3;
            4: m = `BPB_MASK_P4;
            5: m = `BPB_MASK_P5;
            6: m = `BPB_MASK_P6;
            7: m = `BPB_MASK_P7;
            8: m = `BPB_MASK_P8;
            9: m = `BPB_MASK_P9;
            default: m = 8'h00;
        endcase
        return m;
    endfunction

    // Input-only ports have no output stage
    function automatic logic is_input_only(input int p);
        return (p == 2) || (p == 7); // [R4]
    endfunction

    // Only ports 0, 3 and 8 own control select registers
    function automatic logic has_fsel(input int p);
        return (p == 0) || (p == 3) || (p == 8); // [R11]
    endfunction

    // Decoded access
    logic [3:0] acc_base;
    logic [3:0] acc_port;
    logic acc_port_ok;
    assign acc_base = reg_addr[7:4];
    assign acc_port = reg_addr[3:0];
    // Port numbers above 9 decode to nothing and read as zero
    assign acc_port_ok = (acc_port <= 4'h9);

    // Working views of the current state
    logic [9:0][7:0] eff_dir;     // Direction seen by port logic
    logic [9:0][7:0] eff_fsel;    // Control select seen by port logic
    logic [9:0][7:0] bus_taken;   // Bits given to the external bus
    logic [9:0][7:0] ctl_val;     // Peripheral value per bit
    logic [9:0][7:0] ctl_drv;     // Peripheral wants to drive
    logic [9:0][7:0] rd_view;     // What a read of each port returns

    // Per-bit views; combinational from the current state and the peripheral inputs
    always_comb
    begin
        for (int p = 0; p < 10; p++)
        begin
            // Port 4 follows the expansion mode register as a whole
            if (p == 4)
            begin
                eff_dir[p] = {8{st_q.memx[`BPB_MEMX_P4_IN]}}; // [R18]
            end
            else if (is_input_only(p))
            begin
                eff_dir[p] = 8'hFF; // [R4]
            end
            else
            begin
                eff_dir[p] = st_q.dir[p];
            end
            // Control select exists only on three ports
            eff_fsel[p] = has_fsel(p) ? (st_q.fsel[p] & port_mask(p)) : 8'h00; // [R11]
            // Bus takeover in external-only mode
            bus_taken[p] = 8'h00;
            if (st_q.ext_s2 && (p == 4 || p == 5))
            begin
                bus_taken[p] = 8'hFF; // [R17]
            end
            else if (st_q.ext_s2 && p == 9)
            begin
                bus_taken[p] = `BPB_P9_BUS_MASK; // [R17]
            end
            // Peripheral signals; port 0 low nibble carries realtime outputs
            ctl_val[p] = ctl_out[p];
            ctl_drv[p] = ctl_dir_out[p];
            if (p == 0)
            begin
                ctl_val[p][3:0] = realtime_out_signals; // [R19]
                ctl_drv[p][3:0] = 4'hF; // [R19]
            end
            // Reads see the synchronised pin, so a pin change shows two edges later
            // Read multiplexer per bit
            for (int b = 0; b < 8; b++)
            begin
                if (eff_fsel[p][b])
                begin
                    if (st_q.dir[p][b])
                    begin
                        // Direction 1: actual pin in both directions
                        rd_view[p][b] = st_q.pin_s2[p][b]; // [R13] [R15] [R19] [R20]
                    end
                    else if (ctl_drv[p][b])
                    begin
                        // Direction 0, output: internal signal
                        rd_view[p][b] = ctl_val[p][b]; // [R14] [R20]
                    end
                    else
                    begin
                        // Direction 0, input: always zero
                        rd_view[p][b] = 1'b0; // [R15] [R20]
                    end
                end
                else if (eff_dir[p][b])
                begin
                    // Input: pin level, latch hidden
                    rd_view[p][b] = st_q.pin_s2[p][b]; // [R8] [R20]
                end
                else
                begin
                    // Output: latch, not pin
                    rd_view[p][b] = st_q.latch[p][b]; // [R6] [R20]
                end
            end
            // Absent and bus-owned bits read as zero
            rd_view[p] = rd_view[p] & port_mask(p) & ~bus_taken[p]; // [R5] [R17]
        end
    end

    // Next state: register writes, synchronisers, pin drive, read data
    always_comb
    begin
        logic [2:0] bit_idx;
        logic [3:0] pidx;
        logic [7:0] wmask; // Valid bits of the addressed port
        logic [7:0] pmask; // Valid bits of the port being driven
        bit_idx = reg_wdata[`BPB_BITOP_IDX_HI:`BPB_BITOP_IDX_LO];
        pidx = acc_port;
        // A function result cannot be bit-selected, so the masks are held here
        wmask = acc_port_ok ? port_mask(int'(pidx)) : 8'h00;
        pmask = 8'h00;
        st_d = st_q;

        // Pins and strap pass two flip-flops before any use
        st_d.pin_s1 = pin_in;
        st_d.pin_s2 = st_q.pin_s1;
        st_d.ext_s1 = ext_mem_only;
        st_d.ext_s2 = st_q.ext_s1;

        // Register writes
        if (reg_wr)
        begin
            if (reg_addr == `BPB_MEMX_ADDR)
            begin
                st_d.memx = reg_wdata; // [R18]
            end
            else if (acc_port_ok)
            begin
                case (acc_base)
                    `BPB_DATA_BASE:
                    begin
                        // Whole-port write lands in the latch whatever the direction
                        if (!is_input_only(int'(pidx)))
                        begin
                            st_d.latch[pidx] = reg_wdata & port_mask(int'(pidx)); // [R7] [R9]
                        end
                    end
                    `BPB_BITOP_BASE:
                    begin
                        // Single-bit set or clear of the latch
                        // Bits beyond the width ignore it, so no phantom latch bit appears
                        if (!is_input_only(int'(pidx)) && wmask[bit_idx])
                        begin
                            st_d.latch[pidx][bit_idx] = reg_wdata[`BPB_BITOP_VAL]; // [R7] [R9]
                        end
                    end
                    `BPB_DIR_BASE:
                    begin
                        // Port 4 and input-only ports keep no direction register
                        // Bits beyond the width are forced to input so they never drive
                        if (!is_input_only(int'(pidx)) && pidx != 4'h4)
                        begin
                            st_d.dir[pidx] = reg_wdata | ~port_mask(int'(pidx));
                        end
                    end
                    `BPB_FSEL_BASE:
                    begin
                        // Rewriting while control inputs run can glitch peripherals
                        // Only three ports own this register; other addresses are dropped
                        if (has_fsel(int'(pidx)))
                        begin
                            st_d.fsel[pidx] = reg_wdata & port_mask(int'(pidx)); // [R11] [R16]
                        end
                    end
                    default:
                    begin
                        // Unmapped: ignored
                    end
                endcase
            end
        end

        // Pin drive, registered so every output leaves a flip-flop
        for (int p = 0; p < 10; p++)
        begin
            // Mask fetched once per port; bits beyond the width stay undriven
            pmask = port_mask(p);
            for (int b = 0; b < 8; b++)
            begin
                if (is_input_only(p) || !pmask[b] || bus_taken[p][b])
                begin
                    // No driver here
                    st_d.pin_out[p][b] = 1'b0; // [R4] [R5] [R17]
                    st_d.pin_oe[p][b] = 1'b0;
                end
                else if (eff_fsel[p][b])
                begin
                    // Peripheral decides drive; direction bit ignored
                    st_d.pin_out[p][b] = ctl_val[p][b]; // [R11] [R12] [R19]
                    st_d.pin_oe[p][b] = ctl_drv[p][b]; // [R12]
                end
                else
                begin
                    // Latch appears as soon as direction turns to output
                    st_d.pin_out[p][b] = st_q.latch[p][b]; // [R6] [R10]
                    st_d.pin_oe[p][b] = ~eff_dir[p][b]; // [R1] [R10]
                end
            end
            // Peripherals see the synchronised pin level on their bits
            st_d.ctl_in[p] = st_q.pin_s2[p] & port_mask(p);
        end

        // Read data stands only in the cycle after the strobe
        st_d.rdata = 8'h00;
        if (reg_rd)
        begin
            if (reg_addr == `BPB_MEMX_ADDR)
            begin
                st_d.rdata = st_q.memx;
            end
            else if (acc_port_ok)
            begin
                case (acc_base)
                    `BPB_DATA_BASE:
                    begin
                        st_d.rdata = rd_view[pidx]; // [R20]
                    end
                    `BPB_DIR_BASE:
                    begin
                        st_d.rdata = st_q.dir[pidx] & port_mask(int'(pidx));
                    end
                    `BPB_FSEL_BASE:
                    begin
                        st_d.rdata = st_q.fsel[pidx];
                    end
                    default:
                    begin
                        st_d.rdata = 8'h00;
                    end
                endcase
            end
        end
    end

    // State register; latches get a constant only because async reset needs one
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q.latch <= {10{`BPB_LATCH_RST}}; // [R2]
            st_q.dir <= {10{`BPB_DIR_RST}}; // [R1]
            st_q.fsel <= {10{`BPB_FSEL_RST}};
            st_q.memx <= `BPB_MEMX_RST; // [R1] [R18]
            // Synchronisers start low; real pin levels arrive two edges after release
            st_q.pin_s1 <= '0;
            st_q.pin_s2 <= '0;
            st_q.ext_s1 <= 1'b0;
            st_q.ext_s2 <= 1'b0;
            st_q.pin_out <= '0;
            st_q.pin_oe <= '0; // [R1]
            st_q.ctl_in <= '0;
            st_q.rdata <= 8'h00;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    // Read data stands one cycle, then drops to zero; the bus never waits
    assign reg_rdata = st_q.rdata;
    assign pin_out = st_q.pin_out;
    assign pin_oe = st_q.pin_oe;
    assign ctl_in = st_q.ctl_in;

endmodule // bpb_port_block
`default_nettype wire

// file: logic/bpb_cfg.svh
// Address map, field positions, masks and reset values of the port block
`ifndef BPB_CFG_SVH
`define BPB_CFG_SVH

// Register address bases; low nibble selects port number 0 to 9
`define BPB_ADDR_W 8
`define BPB_DATA_BASE 4'h0
`define BPB_DIR_BASE 4'h1
`define BPB_FSEL_BASE 4'h2
`define BPB_BITOP_BASE 4'h4
`define BPB_MEMX_ADDR 8'h30

// Bit operation write data layout
`define BPB_BITOP_IDX_HI 2
`define BPB_BITOP_IDX_LO 0
`define BPB_BITOP_VAL 3

// Memory expansion mode register fields
`define BPB_MEMX_P4_IN 0
`define BPB_MEMX_RST 8'h01

// Valid bit masks per port
`define BPB_MASK_P0 8'hFF
`define BPB_MASK_P1 8'hFF
`define BPB_MASK_P2 8'h3F
`define BPB_MASK_P3 8'h7F
`define BPB_MASK_P4 8'hFF
`define BPB_MASK_P5 8'hFF
`define BPB_MASK_P6 8'h00
`define BPB_MASK_P7 8'hFF
`define BPB_MASK_P8 8'h3F
`define BPB_MASK_P9 8'h0F

// Bits of port 9 taken by the external bus
`define BPB_P9_BUS_MASK 8'h03

// Reset values
`define BPB_DIR_RST 8'hFF
`define BPB_FSEL_RST 8'h00
`define BPB_LATCH_RST 8'h00

`endif

// file: logic/bpb_pkg.sv
// Types shared by the port block
`default_nettype none
package bpb_pkg;
    // Number of port slots, index equals port number
    localparam int NPORT = 10;

    // Per-port byte array
    typedef logic [NPORT-1:0][7:0] bpb_bytes_t;

    // Whole state of the port block
    typedef struct packed {
        bpb_bytes_t latch;     // Output latches
        bpb_bytes_t dir;       // Direction bits, 1 = input
        bpb_bytes_t fsel;      // Control select bits
        logic [7:0] memx;      // Memory expansion mode register
        bpb_bytes_t pin_s1;    // Pin synchroniser stage 1
        bpb_bytes_t pin_s2;    // Pin synchroniser stage 2
        logic ext_s1;          // External-only strap stage 1
        logic ext_s2;          // External-only strap stage 2
        bpb_bytes_t pin_out;   // Registered pin drive values
        bpb_bytes_t pin_oe;    // Registered pin enables
        bpb_bytes_t ctl_in;    // Registered pin levels to peripherals
        logic [7:0] rdata;     // Registered read data
    } bpb_state_s;
endpackage
`default_nettype wire

// file: tb/bpb_port_block_sva.sv
// Assertion checker for the port block
`timescale 1ns/10ps
`default_nettype none
module bpb_port_block_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins
    input wire logic [9:0][7:0] pin_in,
    input wire logic [9:0][7:0] pin_out,
    input wire logic [9:0][7:0] pin_oe,
    input wire logic ext_mem_only
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Nothing drives straight out of reset
    property p_rst_idle; $rose(rst_n) |-> pin_oe == '0; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("pin driven after reset");
    // Input-only ports never drive
    property p_in_only; pin_oe[2] == 8'h00 && pin_oe[7] == 8'h00; endproperty
    a_in_only: assert property (p_in_only) else $error("input-only port driven");
    // Bits past each width stay quiet
    property p_width;
        (pin_oe[3][7] | (|pin_oe[8][7:6]) | (|pin_oe[9][7:4]) | (|pin_oe[6])) == 1'b0;
    endproperty
    a_width: assert property (p_width) else $error("pin beyond width driven");
    // Direction write reaches the enables two cycles on
    property p_dir_oe; reg_wr && reg_addr == 8'h11 |-> ##2 pin_oe[1] == ~$past(reg_wdata, 2);
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("enable not from direction");
    // Latch write shows on every driven bit
    property p_latch_out;
        reg_wr && reg_addr == 8'h01 |->
            ##2 ((pin_out[1] ^ $past(reg_wdata, 2)) & pin_oe[1]) == 8'h00;
    endproperty
    a_latch_out: assert property (p_latch_out) else $error("driven bit not latch");
    // Bus-taken pins are let go
    property p_ext;
        ext_mem_only [*5] |-> (pin_oe[4] | pin_oe[5] | {6'h00, pin_oe[9][1:0]}) == 8'h00;
    endproperty
    a_ext: assert property (p_ext) else $error("bus pin still driven");
    // Input port read follows a steady pin
    property p_in_read;
        $stable(pin_in[7]) [*3] ##0 (reg_rd && reg_addr == 8'h07) |=>
            reg_rdata == $past(pin_in[7]);
    endproperty
    a_in_read: assert property (p_in_read) else $error("input read not pin");
    // Read data only in the cycle after a read
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    // Main scenarios reached
    c_ctl_rd: cover property (reg_rd && reg_addr == 8'h08);
    c_ext: cover property (ext_mem_only [*5]);
    c_rt: cover property (pin_oe[0][3:0] == 4'hF);
endmodule // bpb_port_block_chk
bind bpb_port_block bpb_port_block_chk u_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .ext_mem_only(ext_mem_only));
`default_nettype wire

// file: tb/bpb_board.sv
// Board model on the far side of the port pins
`timescale 1ns/10ps
`default_nettype none
module bpb_board (
    // Block side
    input wire logic [9:0][7:0] pin_out,
    input wire logic [9:0][7:0] pin_oe,
    // Level the board puts on pins nobody else drives
    input wire logic [9:0][7:0] board_val,
    // Resolved pin level
    output logic [9:0][7:0] pin_in
);
    // A driving block wins, so contention with the board value goes unseen
    assign pin_in = (pin_out & pin_oe) | (board_val & ~pin_oe);
endmodule // bpb_board
`default_nettype wire

// file: tb/test_bidirectional_port_block.sv
// Self-checking bench for the port block
`timescale 1ns/10ps
`default_nettype none
module test_bidirectional_port_block;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [9:0][7:0] pin_in, pin_out, pin_oe, ctl_in;
    logic [9:0][7:0] board_val = '0;
    logic [9:0][7:0] ctl_out = '0;
    logic [9:0][7:0] ctl_dir_out = '0;
    logic [3:0] rt_sig = 4'h0;
    logic ext_mem_only = 1'b0;
    int n_mismatch = 0;
    int num_checks = 0;
    // 200 MHz clock
    always #2.5 clk = ~clk;
    bpb_port_block dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .ctl_out(ctl_out), .ctl_dir_out(ctl_dir_out),
        .realtime_out_signals(rt_sig), .ctl_in(ctl_in), .ext_mem_only(ext_mem_only));
    bpb_board board (.pin_out(pin_out), .pin_oe(pin_oe), .board_val(board_val), .pin_in(pin_in));
    // Byte compare, counted
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read strobe, data picked in the following cycle only
    task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(what, exp, reg_rdata);
    endtask
    // Pin register, both synchroniser stages and the ctl_in register need four edges
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask
    // Verdict and end of run
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Hang guard
    initial
    begin
        #200000;
        n_mismatch++;
        end_of_test();
    end
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        board_val[1] <= 8'h3C;
        settle();
        for (int p = 0; p < 10; p++)
            chk("oe after reset", 8'h00, pin_oe[p]);
        rdc("p1 input", 8'h01, 8'h3C);
        rdc("p1 dir reset", 8'h11, 8'hFF);
        $display("reset test done");
        // Latch loaded while input, then low nibble made output
        wr(8'h01, 8'hA5);
        rdc("p1 latch hidden", 8'h01, 8'h3C);
        wr(8'h11, 8'hF0);
        settle();
        chk("oe p1", 8'h0F, pin_oe[1]);
        chk("out p1", 8'h05, pin_out[1] & 8'h0F);
        rdc("p1 mixed", 8'h01, 8'h35);
        wr(8'h41, 8'h09);
        wr(8'h41, 8'h00);
        settle();
        rdc("p1 bit ops", 8'h01, 8'h36);
        wr(8'h01, 8'h5A);
        settle();
        chk("out p1 rewrite", 8'h0A, pin_out[1] & 8'h0F);
        $display("latch test done");
        // Input-only ports, widths, holes in the map
        @(posedge clk);
        board_val[2] <= 8'hFF;
        board_val[3] <= 8'hFF;
        board_val[7] <= 8'h96;
        wr(8'h02, 8'hFF);
        wr(8'h12, 8'h00);
        wr(8'h17, 8'h00);
        settle();
        chk("oe p2", 8'h00, pin_oe[2]);
        chk("oe p7", 8'h00, pin_oe[7]);
        rdc("p2 width", 8'h02, 8'h3F);
        rdc("p3 width", 8'h03, 8'h7F);
        rdc("p7", 8'h07, 8'h96);
        rdc("unmapped", 8'h5F, 8'h00);
        $display("input-only test done");
        // Port 8: bit 0 control output, bit 1 control input
        @(posedge clk);
        ctl_out[8] <= 8'h01;
        ctl_dir_out[8] <= 8'h01;
        board_val[8] <= 8'h3E;
        wr(8'h08, 8'h14);
        wr(8'h28, 8'h03);
        settle();
        chk("oe p8 ctl", 8'h01, pin_oe[8]);
        chk("out p8 ctl", 8'h01, pin_out[8] & 8'h01);
        chk("ctl_in p8", 8'h3F, ctl_in[8]);
        rdc("p8 dir set", 8'h08, 8'h3F);
        rdc("p8 fsel", 8'h28, 8'h03);
        wr(8'h18, 8'h00);
        settle();
        chk("oe p8 dir clr", 8'h3D, pin_oe[8]);
        rdc("p8 dir clr", 8'h08, 8'h15);
        $display("control test done");
        // Port 0 low nibble carries the realtime outputs
        @(posedge clk);
        rt_sig <= 4'hA;
        wr(8'h20, 8'h0F);
        settle();
        chk("oe p0 rt", 8'h0F, pin_oe[0]);
        chk("out p0 rt", 8'h0A, pin_out[0] & 8'h0F);
        rdc("p0 rt pin", 8'h00, 8'h0A);
        $display("realtime test done");
        // Port 4 set by the expansion register, then bus takeover
        wr(8'h04, 8'h5A);
        wr(8'h30, 8'h00);
        rdc("memx", 8'h30, 8'h00);
        wr(8'h14, 8'hFF);
        wr(8'h19, 8'h00);
        settle();
        chk("oe p4", 8'hFF, pin_oe[4]);
        chk("out p4", 8'h5A, pin_out[4]);
        chk("oe p9", 8'h0F, pin_oe[9]);
        @(posedge clk);
        ext_mem_only <= 1'b1;
        settle();
        chk("oe p4 ext", 8'h00, pin_oe[4]);
        chk("oe p9 ext", 8'h0C, pin_oe[9]);
        rdc("p4 ext", 8'h04, 8'h00);
        $display("external mode test done");
        end_of_test();
    end
endmodule // test_bidirectional_port_block
`default_nettype wire
